// File: verilog/pwt_pkg.sv
// Constants and types shared by the programmable watchdog timer
package pwt_pkg;

	// Bus and data widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_RELOAD = 8'h86;
	localparam logic [7:0] OFS_INT_ENABLE_CTL0   = 8'hA8;
	localparam logic [7:0] OFS_IP0    = 8'hA9;
	localparam logic [7:0] OFS_INT_ENABLE_CTL1   = 8'hB8;

	// Reset values
	localparam logic [7:0] RST_RELOAD = 8'h00;
	localparam logic [7:0] RST_INT_ENABLE_CTL0   = 8'h00;
	localparam logic [7:0] RST_IP0    = 8'h00;
	localparam logic [7:0] RST_INT_ENABLE_CTL1   = 8'h00;

	// Field positions
	localparam int BIT_PSEL  = 7;
	localparam int BIT_ARM   = 6;
	localparam int BIT_START = 6;
	localparam int BIT_STAT  = 6;

	// Counter layout
	localparam int CNT_W = 15;
	localparam int HI_W  = 7;
	localparam int LO_W  = 8;
	localparam logic [LO_W-1:0]  LO_CLEAR      = 8'h00;
	localparam logic [CNT_W-1:0] TIMEOUT_STATE = 15'h7FFC;
	localparam logic [CNT_W-1:0] CNT_ONE       = 15'h0001;

	// Prescaler and reset pulse counts
	localparam logic [3:0] PRE16_MAX   = 4'hF;
	localparam logic [3:0] PRE16_ONE   = 4'h1;
	localparam int         PULSE_W     = 8;
	localparam logic [7:0] PULSE_SHORT = 8'h08;
	localparam logic [7:0] PULSE_LONG  = 8'h80;
	localparam logic [7:0] PULSE_ONE   = 8'h01;
	localparam logic [7:0] PULSE_NONE  = 8'h00;

	// Clock period of the machine clock
	localparam int CLK_PERIOD_NS = 100;

	// Register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} pwt_req_s;

	// Whole state of the watchdog
	typedef struct packed {
		logic [7:0]         reload;
		logic [7:0]         int_enable_ctl0;
		logic [7:0]         ip0;
		logic [7:0]         int_enable_ctl1;
		logic               arm_age;
		logic               div2;
		logic [3:0]         pre16;
		logic [CNT_W-1:0]   count;
		logic [PULSE_W-1:0] pulse;
		logic               wdt_rst;
		logic               osc_s1;
		logic               osc_s2;
		logic [DATA_W-1:0]  rdata;
	} pwt_state_s;

	localparam pwt_state_s STATE_RST = '{
		reload:  RST_RELOAD,
		int_enable_ctl0:    RST_INT_ENABLE_CTL0,
		ip0:     RST_IP0,
		int_enable_ctl1:    RST_INT_ENABLE_CTL1,
		arm_age: 1'b0,
		div2:    1'b0,
		pre16:   4'h0,
		count:   15'h0000,
		pulse:   PULSE_NONE,
		wdt_rst: 1'b0,
		osc_s1:  1'b0,
		osc_s2:  1'b0,
		rdata:   8'h00
	};

endpackage

// File: verilog/pwt_watchdog.sv
// Programmable watchdog timer with its control and status registers
//
// Summary of operation
// - Fifteen-bit up-counter behind divide-by-two prescaler
// - Select bit adds a divide-by-sixteen stage
// - Only upper seven counter bits are programmable
// - Reload low seven bits preset high part
// - Default reload gives default time-out period
// - Start loads counter from reload value
// - Start or refresh zeroes low eight bits
// - Resets clear the whole reload register
// - Reload writable outside the reset pulse, used at next load
// - Start bit starts; only external or oscillator reset stops it
// - Arm then start write refreshes counter
// - Arm bit self-clears in second cycle
// - Counter halts in idle or power-down
// - Watchdog reset entered at state 7FFC
// - Reset pulse 8 or 128 cycles long
// - Watchdog reset sets status, keeps running
// - Status flag: hardware set, software writable
// - Oscillator reset stops timer, keeps status
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module pwt_watchdog
(
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     srst,
	// Register port
	input  wire pwt_pkg::pwt_req_s        req,
	output logic [pwt_pkg::DATA_W-1:0]    rd_data,
	// Processor power state
	input  wire logic                     idle_mode,
	input  wire logic                     power_down,
	// Oscillator monitor reset request, asynchronous
	input  wire logic                     osc_mon_rst,
	// Watchdog results
	output logic                          wdt_rst,
	output logic                          wdt_running,
	output logic                          timeout_status
);
	import pwt_pkg::*;

	pwt_state_s s;       // Registered state
	pwt_state_s next_s;  // Next state

	// Decoded strobes and helpers
	logic running;        // Start bit holds the timer running
	logic halted;         // Power saving mode freezes the count
	logic tick2;          // Divide-by-two stage output
	logic tick;           // Counter increment enable
	logic in_reset;       // Watchdog reset pulse active
	logic wr_int_enable_ctl1_start;  // Write setting the start bit
	logic do_load;        // Start or refresh this cycle
	logic timeout;        // Counter reaches its trip state

	// Next-state logic
	always_comb
	begin
		next_s = s;
		running = s.int_enable_ctl1[BIT_START];
		halted = idle_mode | power_down;
		in_reset = (s.pulse != PULSE_NONE);

		// Oscillator monitor request through two flops
		next_s.osc_s1 = osc_mon_rst;
		next_s.osc_s2 = s.osc_s1;

		// halt when idle
		// Prescalers only move while running and awake
		tick2 = 1'b0;
		tick = 1'b0;
		if (running && !halted)
		begin
			next_s.div2 = ~s.div2;
			tick2 = s.div2;
			if (tick2)
			begin
				next_s.pre16 = s.pre16 + PRE16_ONE;
			end
			if (s.reload[BIT_PSEL])
			begin
				tick = tick2 && (s.pre16 == PRE16_MAX);
			end
			else
			begin
				tick = tick2;
			end
		end

		if (tick)
		begin
			next_s.count = s.count + CNT_ONE;
		end

		// arm auto clear
		// Arm lives in its set cycle and the one after
		if (s.int_enable_ctl0[BIT_ARM])
		begin
			if (s.arm_age)
			begin
				next_s.int_enable_ctl0[BIT_ARM] = 1'b0;
				next_s.arm_age = 1'b0;
			end
			else
			begin
				next_s.arm_age = 1'b1;
			end
		end

		// Register writes, ignored while the device is held in reset
		wr_int_enable_ctl1_start = req.wr && !in_reset && (req.addr == OFS_INT_ENABLE_CTL1)
			&& req.wdata[BIT_START];
		do_load = 1'b0;
		if (req.wr && !in_reset)
		begin
			case (req.addr)
				OFS_RELOAD:
				begin
					next_s.reload = req.wdata;
				end
				OFS_INT_ENABLE_CTL0:
				begin
					// A fresh set restarts the arm lifetime
					next_s.int_enable_ctl0 = req.wdata;
					next_s.arm_age = 1'b0;
				end
				OFS_IP0:
				begin
					next_s.ip0 = req.wdata;
				end
				OFS_INT_ENABLE_CTL1:
				begin
					// cannot be stopped
					// Writing zero never clears a running start bit
					next_s.int_enable_ctl1 = req.wdata;
					next_s.int_enable_ctl1[BIT_START] = running | req.wdata[BIT_START];
				end
				default:
				begin
					// Unmapped writes are dropped
					next_s.reload = next_s.reload;
				end
			endcase
		end

		// arm then start
		// A start write while running refreshes only when armed
		if (wr_int_enable_ctl1_start)
		begin
			if (!running)
			begin
				do_load = 1'b1;
			end
			else if (s.int_enable_ctl0[BIT_ARM])
			begin
				do_load = 1'b1;
				next_s.int_enable_ctl0[BIT_ARM] = 1'b0;
				next_s.arm_age = 1'b0;
			end
		end

		if (do_load)
		begin
			next_s.count = {s.reload[HI_W-1:0], LO_CLEAR};
		end

		// trip at 7FFC
		// A refresh in the same cycle wins over the trip
		timeout = tick && !do_load
			&& ((s.count + CNT_ONE) == TIMEOUT_STATE);

		// Reset pulse countdown
		if (in_reset)
		begin
			next_s.pulse = s.pulse - PULSE_ONE;
		end

		if (timeout)
		begin
			next_s.pulse = s.reload[BIT_PSEL] ? PULSE_LONG : PULSE_SHORT;
			next_s.reload = RST_RELOAD;
			// like external reset
			// Other register bits go to reset, the start and status bits are set
			next_s.int_enable_ctl0 = RST_INT_ENABLE_CTL0;
			next_s.arm_age = 1'b0;
			next_s.int_enable_ctl1 = RST_INT_ENABLE_CTL1;
			next_s.int_enable_ctl1[BIT_START] = 1'b1;
			next_s.ip0 = RST_IP0;
			next_s.ip0[BIT_STAT] = 1'b1;
		end

		// oscillator reset
		// Stops and clears everything but the status flag
		if (s.osc_s2)
		begin
			next_s.reload = RST_RELOAD;
			next_s.int_enable_ctl0 = RST_INT_ENABLE_CTL0;
			next_s.int_enable_ctl1 = RST_INT_ENABLE_CTL1;
			next_s.ip0 = RST_IP0;
			next_s.ip0[BIT_STAT] = s.ip0[BIT_STAT];
			next_s.arm_age = 1'b0;
			next_s.div2 = 1'b0;
			next_s.pre16 = 4'h0;
			next_s.count = '0;
			next_s.pulse = PULSE_NONE;
		end

		// Reset output follows the pulse counter
		next_s.wdt_rst = (next_s.pulse != PULSE_NONE);

		// Read data stands one cycle only, zero otherwise
		next_s.rdata = 8'h00;
		if (req.rd)
		begin
			case (req.addr)
				OFS_RELOAD: next_s.rdata = s.reload;
				OFS_INT_ENABLE_CTL0:   next_s.rdata = s.int_enable_ctl0;
				OFS_IP0:    next_s.rdata = s.ip0;
				OFS_INT_ENABLE_CTL1:   next_s.rdata = s.int_enable_ctl1;
				default:    next_s.rdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			s <= STATE_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Outputs straight from flops
	assign rd_data        = s.rdata;
	assign wdt_rst        = s.wdt_rst;
	assign wdt_running    = s.int_enable_ctl1[BIT_START];
	assign timeout_status = s.ip0[BIT_STAT];

	// Checks on the watchdog behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// Armed start write while running
	sequence refresh_req;
		req.wr && (req.addr == OFS_INT_ENABLE_CTL1) && req.wdata[BIT_START]
			&& s.int_enable_ctl1[BIT_START] && s.int_enable_ctl0[BIT_ARM]
			&& (s.pulse == PULSE_NONE) && !s.osc_s2;
	endsequence

	// Start write while stopped
	sequence start_req;
		req.wr && (req.addr == OFS_INT_ENABLE_CTL1) && req.wdata[BIT_START]
			&& !s.int_enable_ctl1[BIT_START] && (s.pulse == PULSE_NONE) && !s.osc_s2;
	endsequence

	refresh_load_a: assert property (refresh_req |=>
		s.count == {$past(s.reload[HI_W-1:0]), LO_CLEAR})
		else $error("refresh did not reload the counter");

	start_load_a: assert property (start_req |=>
		s.int_enable_ctl1[BIT_START] && s.count == {$past(s.reload[HI_W-1:0]), LO_CLEAR})
		else $error("start did not load the counter");

	arm_clear_a: assert property ((s.int_enable_ctl0[BIT_ARM] && s.arm_age
		&& !(req.wr && req.addr == OFS_INT_ENABLE_CTL0 && req.wdata[BIT_ARM]))
		|=> !s.int_enable_ctl0[BIT_ARM])
		else $error("arm bit lived past its second cycle");

	no_stop_a: assert property ((s.int_enable_ctl1[BIT_START] && !s.osc_s2)
		|=> s.int_enable_ctl1[BIT_START])
		else $error("watchdog stopped while running");

	halt_hold_a: assert property (((idle_mode || power_down)
		&& !(req.wr && req.addr == OFS_INT_ENABLE_CTL1) && !s.osc_s2)
		|=> s.count == $past(s.count))
		else $error("counter moved in a power saving mode");

	trip_state_a: assert property ($rose(s.wdt_rst) |->
		s.count == TIMEOUT_STATE)
		else $error("watchdog reset not at counter state 7FFC");

	// Short reset: eight cycles high, then low
	sequence short_tail;
		s.wdt_rst[*8] ##1 !s.wdt_rst;
	endsequence

	// Long reset: still high at its last cycle, low after
	sequence long_tail;
		##127 s.wdt_rst ##1 !s.wdt_rst;
	endsequence

	short_pulse_a: assert property (disable iff (srst || s.osc_s2)
		($rose(s.wdt_rst) && s.pulse == PULSE_SHORT)
		|-> short_tail)
		else $error("short watchdog reset not 8 cycles");

	long_pulse_a: assert property (disable iff (srst || s.osc_s2)
		($rose(s.wdt_rst) && s.pulse == PULSE_LONG)
		|-> long_tail)
		else $error("long watchdog reset not 128 cycles");

	// arm survives first cycle
	// An early clear would shrink the refresh window to one cycle
	arm_hold_a: assert property ((s.int_enable_ctl0[BIT_ARM] && !s.arm_age
		&& !req.wr && !s.osc_s2)
		|=> (s.int_enable_ctl0[BIT_ARM] || s.wdt_rst))
		else $error("arm bit cleared before its second cycle");

	reload_write_a: assert property ((req.wr && req.addr == OFS_RELOAD
		&& !in_reset && !timeout && !s.osc_s2)
		|=> s.reload == $past(req.wdata))
		else $error("reload write did not land");

	read_back_a: assert property ((req.rd && req.addr == OFS_RELOAD)
		|=> rd_data == $past(s.reload))
		else $error("reload read returned a wrong value");

	// count steps by one
	// Only a load or an oscillator reset may jump the counter
	count_step_a: assert property ((!do_load && !s.osc_s2)
		|=> (s.count == $past(s.count)
		|| s.count == $past(s.count) + CNT_ONE))
		else $error("counter jumped without a load");

	stopped_hold_a: assert property ((!s.int_enable_ctl1[BIT_START] && !s.osc_s2
		&& !(req.wr && req.addr == OFS_INT_ENABLE_CTL1))
		|=> s.count == $past(s.count))
		else $error("counter moved before the start");

	reset_effects_a: assert property ($rose(s.wdt_rst) |->
		s.ip0[BIT_STAT] && s.int_enable_ctl1[BIT_START] && s.reload == RST_RELOAD)
		else $error("watchdog reset effects missing");

	osc_keep_a: assert property (s.osc_s2 |=>
		!s.int_enable_ctl1[BIT_START] && s.ip0[BIT_STAT] == $past(s.ip0[BIT_STAT]))
		else $error("oscillator reset mishandled status or timer");

endmodule

`default_nettype wire

// File: tb/pwt_watchdog_tb_top.sv
// Self-checking bench for the watchdog timer block
`timescale 1ns/10ps
`default_nettype none

module pwt_watchdog_tb_top;
	import pwt_pkg::*;

	logic              ref_clk;     // Machine clock
	logic              srst;        // External reset
	pwt_req_s          req;         // Register request
	logic [DATA_W-1:0] rd_data;     // Read data
	logic              idle_mode;   // Idle request
	logic              power_down;  // Power-down request
	logic              osc_mon_rst; // Oscillator monitor reset
	logic              wdt_rst;     // Watchdog reset out
	logic              wdt_running; // Start bit
	logic              timeout_status; // Status flag
	int                fail_count;  // Mismatches
	int                compares;    // Comparisons
	int                cycles;      // Hang guard
	int                n;           // Measured cycles

	pwt_watchdog u_dut
	(
		.ref_clk        (ref_clk),
		.srst           (srst),
		.req            (req),
		.rd_data        (rd_data),
		.idle_mode      (idle_mode),
		.power_down     (power_down),
		.osc_mon_rst    (osc_mon_rst),
		.wdt_rst        (wdt_rst),
		.wdt_running    (wdt_running),
		.timeout_status (timeout_status)
	);

	// Clock of 100 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Compare one value and count it
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		if (seen !== exp)
			fail_count++;
	endtask

	// Verdict and end of run
	task final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One bus cycle; strobes drop only via the next call
	task bus(input logic [7:0] a, input logic [7:0] d,
		input logic w, input logic r);
		@(posedge ref_clk);
		req <= '{a, d, w, r};
	endtask

	// Single write, then idle; outputs settle before return
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, d, 1'b1, 1'b0);
		bus(8'h00, 8'h00, 1'b0, 1'b0);
		#1;
	endtask

	// Read and compare in the answer cycle
	task rd(input logic [7:0] a, input logic [7:0] exp);
		bus(a, 8'h00, 1'b0, 1'b1);
		bus(8'h00, 8'h00, 1'b0, 1'b0);
		#1;
		chk(16'(rd_data), 16'(exp));
	endtask

	// Arm then start on back-to-back cycles
	task refresh();
		bus(OFS_INT_ENABLE_CTL0, 8'h40, 1'b1, 1'b0);
		bus(OFS_INT_ENABLE_CTL1, 8'h40, 1'b1, 1'b0);
		bus(8'h00, 8'h00, 1'b0, 1'b0);
	endtask

	// Cycles until the reset pulse starts
	task trip_wait(output int k);
		k = 0;
		while (wdt_rst !== 1'b1 && k < 9000)
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end
	endtask

	// Cycles the reset pulse stays high
	task pulse_len(output int k);
		k = 0;
		while (wdt_rst === 1'b1 && k < 300)
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end
	endtask

	// Hang guard; whole run needs about 10800 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			fail_count++;
			final_report();
		end
	end

	// Main sequence
	initial
	begin
		fail_count = 0;
		compares = 0;
		cycles = 0;
		srst = 1'b1;
		req = '0;
		idle_mode = 1'b0;
		power_down = 1'b0;
		osc_mon_rst = 1'b0;
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		// Reset values, unmapped place, plain storage
		rd(OFS_RELOAD, RST_RELOAD);
		rd(OFS_INT_ENABLE_CTL0, RST_INT_ENABLE_CTL0);
		rd(OFS_IP0, RST_IP0);
		rd(OFS_INT_ENABLE_CTL1, RST_INT_ENABLE_CTL1);
		wr(8'h10, 8'h5A);
		rd(8'h10, 8'h00);
		wr(OFS_RELOAD, 8'hA5);
		rd(OFS_RELOAD, 8'hA5);
		chk(16'(wdt_running), 16'h0000);
		$display("test registers done");
		// Minimum period: 252 ticks of two cycles
		wr(OFS_RELOAD, 8'h7F);
		wr(OFS_INT_ENABLE_CTL1, 8'h40);
		chk(16'(wdt_running), 16'h0001);
		trip_wait(n);
		chk(16'(n >= 502 && n <= 506), 16'h0001);
		pulse_len(n);
		chk(16'(n), 16'h0008);
		chk(16'(wdt_running), 16'h0001);
		chk(16'(timeout_status), 16'h0001);
		rd(OFS_RELOAD, 8'h00);
		rd(OFS_IP0, 8'h40);
		$display("test timeout done");
		// Refresh reloads; a late start is not a refresh
		wr(OFS_RELOAD, 8'h7F);
		refresh();
		repeat (300) @(posedge ref_clk);
		bus(OFS_INT_ENABLE_CTL0, 8'h40, 1'b1, 1'b0);
		bus(8'h00, 8'h00, 1'b0, 1'b0);
		bus(8'h00, 8'h00, 1'b0, 1'b0);
		bus(OFS_INT_ENABLE_CTL1, 8'h40, 1'b1, 1'b0);
		bus(8'h00, 8'h00, 1'b0, 1'b0);
		trip_wait(n);
		chk(16'(n >= 193 && n <= 205), 16'h0001);
		pulse_len(n);
		$display("test refresh done");
		// Idle and power-down freeze the count
		wr(OFS_RELOAD, 8'h7F);
		refresh();
		idle_mode <= 1'b1;
		repeat (500) @(posedge ref_clk);
		idle_mode <= 1'b0;
		power_down <= 1'b1;
		repeat (500) @(posedge ref_clk);
		power_down <= 1'b0;
		#1;
		chk(16'(wdt_rst), 16'h0000);
		trip_wait(n);
		chk(16'(n >= 498 && n <= 506), 16'h0001);
		pulse_len(n);
		$display("test halt done");
		// Extra divide-by-16 stage: 252 ticks of 32 cycles
		wr(OFS_RELOAD, 8'hFF);
		refresh();
		trip_wait(n);
		chk(16'(n >= 8030 && n <= 8100), 16'h0001);
		pulse_len(n);
		chk(16'(n), 16'h0080);
		$display("test prescale done");
		// Status flag by software, oscillator and external reset
		wr(OFS_IP0, 8'h00);
		rd(OFS_IP0, 8'h00);
		wr(OFS_IP0, 8'h40);
		chk(16'(timeout_status), 16'h0001);
		osc_mon_rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		osc_mon_rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(16'(wdt_running), 16'h0000);
		chk(16'(timeout_status), 16'h0001);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		#1;
		chk(16'(timeout_status), 16'h0000);
		$display("test status done");
		final_report();
	end
endmodule

`default_nettype wire
